// >>> hdl/serial_channel_pkg.sv
package serial_channel_pkg;
  // Register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int RELOAD_W = 13;

  // Register indices
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_BAUD   = 3'h1;
  localparam logic [2:0] REG_TXDATA = 3'h2;
  localparam logic [2:0] REG_RXDATA = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;

  // Control field positions
  localparam int CTL_W      = 10;
  localparam int CTL_MODE   = 0;
  localparam int CTL_STOP2  = 2;
  localparam int CTL_PAR_EN = 3;
  localparam int CTL_FRM_EN = 4;
  localparam int CTL_OVR_EN = 5;
  localparam int CTL_LOOP   = 6;
  localparam int CTL_PRESEL = 7;
  localparam int CTL_RX_EN  = 8;
  localparam int CTL_RUN    = 9;

  // Status field positions
  localparam int STS_BUSY  = 0;
  localparam int STS_FULL  = 1;
  localparam int STS_PAR   = 2;
  localparam int STS_FRM   = 3;
  localparam int STS_OVR   = 4;

  // Operating modes held in the mode field
  localparam logic [1:0] MODE_SYNC   = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_ASYNC9 = 2'h2;
  localparam logic [1:0] MODE_WAKE   = 2'h3;

  // Values after reset
  localparam logic [CTL_W-1:0]    CTRL_RST   = 10'h001;
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 13'h0000;

  // Prescaler ratios for select 0 and 1, and oversampling counts
  localparam logic [1:0] PRE_DIV0  = 2'h2;
  localparam logic [1:0] PRE_DIV1  = 2'h3;
  localparam logic [3:0] OVS_LAST  = 4'hF;
  localparam logic [3:0] OVS_MID   = 4'h7;
  localparam logic [3:0] SYNC_HALF = 4'h7;

  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
endpackage : serial_channel_pkg

// >>> hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_t;

  sync_t q;
  sync_t d;

  // First stage feeds only the second
  always_comb begin
    d.meta   = din;
    d.stable = q.meta;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign dout = q.stable;
endmodule : pin_sync

// >>> hdl/baud_gen.sv
`timescale 1ns/1ns
module baud_gen #(
  parameter int RELOAD_W = serial_channel_pkg::RELOAD_W
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // Setup
  input  wire logic                run,
  input  wire logic                baud_prescale_select,
  input  wire logic [RELOAD_W-1:0] reload,
  // Oversampling tick, sixteen per bit
  output logic                     tick
);
  typedef struct packed {
    logic [1:0]          pre;
    logic [RELOAD_W-1:0] cnt;
    logic                tick;
  } bg_t;

  bg_t q;
  bg_t d;
  logic [1:0] pre_last;

  // Divide by 2 or 3, then by reload plus one
  always_comb begin
    d = q;
    d.tick = 1'b0;
    pre_last = baud_prescale_select ? serial_channel_pkg::PRE_DIV1 - 2'h1
                                    : serial_channel_pkg::PRE_DIV0 - 2'h1;
    if (!run) begin
      d.pre = 2'h0;
      d.cnt = reload;
    end else if (q.pre >= pre_last) begin
      d.pre = 2'h0;
      if (q.cnt == '0) begin
        d.cnt  = reload;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt - 1'b1;
      end
    end else begin
      d.pre = q.pre + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule : baud_gen

// >>> hdl/async_sync_serial_channel.sv
`timescale 1ns/1ns
// What this block does
// - Bit timing from reloadable clock divider
// - Reload zero gives clock over 32 or 48
// - Separate transmit, receive and error requests
// - Start, 8 or 9 data, 1-2 stops
// - Ninth wake bit marks address bytes
// - Synchronous bytes, block drives shift clock
// - Least significant bit shifted first
// - Loopback feeds transmit output to receiver
// - Each error check enabled separately
// - Parity generated on send, checked on receive
// - Low stop bit flags framing error
// - Unread buffer overwritten flags overrun
module async_sync_serial_channel #(
  parameter int RELOAD_W = serial_channel_pkg::RELOAD_W
) (
  // System
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_b,
  // Register port
  input  wire logic [serial_channel_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [serial_channel_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [serial_channel_pkg::DATA_W-1:0] reg_rdata,
  // Serial pins; in synchronous mode txd is the shift clock
  output logic                                       txd,
  input  wire logic                                  rxd_i,
  output logic                                       rxd_o,
  output logic                                       rxd_oe,
  // Requests
  output logic                                       tx_irq,
  output logic                                       rx_irq,
  output logic                                       err_irq
);
  typedef struct packed {
    logic [serial_channel_pkg::CTL_W-1:0]  ctrl;
    logic [RELOAD_W-1:0]                   reload;
    serial_channel_pkg::tx_state_t         tx_st;
    logic [11:0]                           tx_sh;
    logic [3:0]                            tx_cnt;
    logic [3:0]                            tx_tk;
    serial_channel_pkg::rx_state_t         rx_st;
    logic [9:0]                            rx_sh;
    logic [3:0]                            rx_cnt;
    logic [3:0]                            rx_tk;
    logic [8:0]                            rx_buf;
    logic                                  rx_full;
    logic                                  rx_prev;
    logic                                  err_par;
    logic                                  err_frm;
    logic                                  err_ovr;
    logic                                  txd;
    logic                                  dout;
    logic                                  doe;
    logic [serial_channel_pkg::DATA_W-1:0] rdata;
    logic                                  tx_irq;
    logic                                  rx_irq;
    logic                                  err_irq;
  } state_t;

  state_t q;
  state_t d;
  logic rst_sync_b;
  logic rxd_s;
  logic tick;
  logic [1:0] mode;
  logic is_sync;
  logic nine;
  logic rx_in;
  logic tx_go;
  logic rx_done;
  logic stop_bad;
  logic par_bad;
  logic [8:0] rx_word;
  logic [9:0] rx_ns;
  logic tx_par;
  logic tx_sh_busy;

  // Reset release and pin input both pass two flops
  pin_sync #(.RST_VAL(1'b0)) u_rst_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     (1'b1),
    .dout    (rst_sync_b)
  );

  pin_sync #(.RST_VAL(1'b1)) u_rxd_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_sync_b),
    .din     (rxd_i),
    .dout    (rxd_s)
  );

  // Oversampling tick from the reload divider
  baud_gen #(.RELOAD_W(RELOAD_W)) u_baud (
    .clk_sys              (clk_sys),
    .rst_b                (rst_sync_b),
    .run                  (q.ctrl[serial_channel_pkg::CTL_RUN]),
    .baud_prescale_select (q.ctrl[serial_channel_pkg::CTL_PRESEL]),
    .reload               (q.reload),
    .tick                 (tick)
  );

  // Frame shape derived from the control word
  assign mode    = q.ctrl[serial_channel_pkg::CTL_MODE +: 2];
  assign is_sync = (mode == serial_channel_pkg::MODE_SYNC);
  assign nine    = (mode == serial_channel_pkg::MODE_ASYNC9) ||
                   (mode == serial_channel_pkg::MODE_WAKE) ||
                   ((mode == serial_channel_pkg::MODE_ASYNC8) &&
                    q.ctrl[serial_channel_pkg::CTL_PAR_EN]);
  // Loopback keeps the pin out of the path so tests need no cable
  assign rx_in   = q.ctrl[serial_channel_pkg::CTL_LOOP] ? (is_sync ? q.dout : q.txd)
                                                        : rxd_s;
  assign tx_go   = reg_wr && (reg_addr == serial_channel_pkg::REG_TXDATA) &&
                   q.ctrl[serial_channel_pkg::CTL_RUN] &&
                   (q.tx_st == serial_channel_pkg::TX_IDLE);
  assign tx_par  = ^reg_wdata[7:0];

  // Next state of the whole channel
  always_comb begin
    d = q;
    d.tx_irq = 1'b0;
    d.rx_irq = 1'b0;
    d.rdata = '0;
    rx_done = 1'b0;
    stop_bad = 1'b0;
    par_bad = 1'b0;
    rx_word = '0;
    rx_ns = {rx_in, q.rx_sh[9:1]};
    // Edge memory idles high, so reset or a low stop bit gives no false start
    d.rx_prev = rx_in;

    // Register writes; error flags clear by writing one
    if (reg_wr) begin
      unique case (reg_addr)
        serial_channel_pkg::REG_CTRL: d.ctrl = reg_wdata[serial_channel_pkg::CTL_W-1:0];
        serial_channel_pkg::REG_BAUD: d.reload = reg_wdata[RELOAD_W-1:0];
        serial_channel_pkg::REG_STATUS: begin
          d.err_par = q.err_par & ~reg_wdata[serial_channel_pkg::STS_PAR];
          d.err_frm = q.err_frm & ~reg_wdata[serial_channel_pkg::STS_FRM];
          d.err_ovr = q.err_ovr & ~reg_wdata[serial_channel_pkg::STS_OVR];
        end
        default: ;
      endcase
    end

    // Register reads, answered one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        serial_channel_pkg::REG_CTRL:   d.rdata = 16'(q.ctrl);
        serial_channel_pkg::REG_BAUD:   d.rdata = 16'(q.reload);
        serial_channel_pkg::REG_RXDATA: begin
          d.rdata = 16'(q.rx_buf);
          d.rx_full = 1'b0;
        end
        serial_channel_pkg::REG_STATUS: begin
          d.rdata = 16'({q.err_ovr, q.err_frm, q.err_par, q.rx_full,
                         q.tx_st != serial_channel_pkg::TX_IDLE});
        end
        default: d.rdata = '0;
      endcase
    end

    // Transmit start; a write while busy or stopped is dropped
    if (tx_go) begin
      d.tx_tk = 4'h0;
      if (is_sync) begin
        d.tx_st = serial_channel_pkg::TX_SYNC;
        d.tx_sh = {4'hF, reg_wdata[7:0]};
        d.tx_cnt = 4'h7;
        d.dout = reg_wdata[0];
        d.doe = ~q.ctrl[serial_channel_pkg::CTL_RX_EN];
      end else begin
        d.tx_st = serial_channel_pkg::TX_ASYNC;
        if (nine) begin
          d.tx_sh = {2'h3, (mode == serial_channel_pkg::MODE_ASYNC8) ? tx_par
                                                                     : reg_wdata[8],
                     reg_wdata[7:0], 1'b0};
        end else begin
          d.tx_sh = {3'h7, reg_wdata[7:0], 1'b0};
        end
        d.tx_cnt = (nine ? 4'h9 : 4'h8) +
                   (q.ctrl[serial_channel_pkg::CTL_STOP2] ? 4'h2 : 4'h1);
        d.txd = 1'b0;
      end
    end

    // Transmit engines
    unique case (q.tx_st)
      serial_channel_pkg::TX_IDLE: ;
      serial_channel_pkg::TX_ASYNC: begin
        if (tick) begin
          d.tx_tk = q.tx_tk + 4'h1;
          if (q.tx_tk == serial_channel_pkg::OVS_LAST) begin
            if (q.tx_cnt == 4'h0) begin
              d.tx_st = serial_channel_pkg::TX_IDLE;
              d.txd = 1'b1;
              d.tx_irq = 1'b1;
            end else begin
              d.tx_cnt = q.tx_cnt - 4'h1;
              d.tx_sh = {1'b1, q.tx_sh[11:1]};
              d.txd = q.tx_sh[1];
            end
          end
        end
      end
      serial_channel_pkg::TX_SYNC: begin
        // Clock idles high; data moves after each rising edge
        if (tick) begin
          d.tx_tk = q.tx_tk + 4'h1;
          if (q.tx_tk == serial_channel_pkg::SYNC_HALF) begin
            d.tx_tk = 4'h0;
            d.txd = ~q.txd;
            if (!q.txd) begin
              d.rx_sh = rx_ns;
              if (q.tx_cnt == 4'h0) begin
                d.tx_st = serial_channel_pkg::TX_IDLE;
                d.doe = 1'b0;
                d.tx_irq = 1'b1;
                rx_done = q.ctrl[serial_channel_pkg::CTL_RX_EN];
                rx_word = {1'b0, rx_ns[9:2]};
              end else begin
                d.tx_cnt = q.tx_cnt - 4'h1;
                d.tx_sh = {1'b1, q.tx_sh[11:1]};
                d.dout = q.tx_sh[1];
              end
            end
          end
        end
      end
      default: d.tx_st = serial_channel_pkg::TX_IDLE;
    endcase

    // Asynchronous receiver, 16 ticks per bit
    unique case (q.rx_st)
      serial_channel_pkg::RX_IDLE: begin
        if (!is_sync && q.ctrl[serial_channel_pkg::CTL_RX_EN] &&
            q.ctrl[serial_channel_pkg::CTL_RUN] && q.rx_prev && !rx_in) begin
          d.rx_st = serial_channel_pkg::RX_START;
          d.rx_tk = 4'h0;
        end
      end
      serial_channel_pkg::RX_START: begin
        // A glitch shorter than half a bit is dropped
        if (tick) begin
          d.rx_tk = q.rx_tk + 4'h1;
          if (q.rx_tk == serial_channel_pkg::OVS_MID) begin
            d.rx_tk = 4'h0;
            d.rx_cnt = 4'h0;
            d.rx_st = rx_in ? serial_channel_pkg::RX_IDLE
                            : serial_channel_pkg::RX_BITS;
          end
        end
      end
      serial_channel_pkg::RX_BITS: begin
        if (tick) begin
          d.rx_tk = q.rx_tk + 4'h1;
          if (q.rx_tk == serial_channel_pkg::OVS_LAST) begin
            d.rx_sh = rx_ns;
            d.rx_cnt = q.rx_cnt + 4'h1;
            // Only the first stop bit is checked; a second one just idles
            if (q.rx_cnt == (nine ? 4'h9 : 4'h8)) begin
              d.rx_st = serial_channel_pkg::RX_IDLE;
              rx_done = 1'b1;
              rx_word = nine ? rx_ns[8:0] : {1'b0, rx_ns[8:1]};
              stop_bad = ~rx_ns[9];
              par_bad = (mode == serial_channel_pkg::MODE_ASYNC8) && (^rx_ns[8:0]);
            end
          end
        end
      end
      default: d.rx_st = serial_channel_pkg::RX_IDLE;
    endcase

    // Completion; hardware sets win over a clear in the same cycle
    if (rx_done) begin
      if (q.rx_full && !d.rx_full ? 1'b0 : q.rx_full) begin
        d.err_ovr = d.err_ovr | q.ctrl[serial_channel_pkg::CTL_OVR_EN];
      end
      d.rx_buf = rx_word;
      d.rx_full = 1'b1;
      d.rx_irq = 1'b1;
      d.err_frm = d.err_frm | (stop_bad & q.ctrl[serial_channel_pkg::CTL_FRM_EN]);
      d.err_par = d.err_par | (par_bad & q.ctrl[serial_channel_pkg::CTL_PAR_EN]);
    end
    d.err_irq = d.err_par | d.err_frm | d.err_ovr;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      q <= '0;
      q.ctrl <= serial_channel_pkg::CTRL_RST;
      q.reload <= serial_channel_pkg::RELOAD_RST;
      q.txd <= 1'b1;
      q.dout <= 1'b1;
      q.rx_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Every output straight from a flop
  assign reg_rdata = q.rdata;
  assign txd       = q.txd;
  assign rxd_o     = q.dout;
  assign rxd_oe    = q.doe;
  assign tx_irq    = q.tx_irq;
  assign rx_irq    = q.rx_irq;
  assign err_irq   = q.err_irq;

  // Async frame in flight, for the start bit check
  assign tx_sh_busy = (q.tx_st == serial_channel_pkg::TX_ASYNC);

  // Checks on the channel behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_b);

  AST_TICK_GAP: assert property (tick |=> !tick)
    else $error("baud tick faster than clock over two");
  AST_START_BIT: assert property (tx_go && !is_sync |=> !txd && tx_sh_busy)
    else $error("async frame did not open with a low start bit");
  AST_LSB_FIRST: assert property (tx_go && !is_sync |=> q.tx_sh[1] == $past(reg_wdata[0]))
    else $error("first data bit is not the lsb");
  AST_CLK_IDLE: assert property (q.tx_st == serial_channel_pkg::TX_IDLE |-> txd)
    else $error("shift clock not high while idle");
  AST_LOOP: assert property (q.ctrl[serial_channel_pkg::CTL_LOOP] && !is_sync &&
                             q.ctrl[serial_channel_pkg::CTL_RX_EN] &&
                             q.ctrl[serial_channel_pkg::CTL_RUN] &&
                             q.rx_st == serial_channel_pkg::RX_IDLE && q.rx_prev && !txd
                             |=> q.rx_st == serial_channel_pkg::RX_START)
    else $error("loopback does not feed transmit line");
  AST_FRAME_ERR: assert property (rx_done && stop_bad &&
                                  q.ctrl[serial_channel_pkg::CTL_FRM_EN] |=> q.err_frm && err_irq)
    else $error("missing stop bit not flagged");
  AST_PAR_OFF: assert property ($rose(q.err_par) |-> $past(q.ctrl[serial_channel_pkg::CTL_PAR_EN]))
    else $error("parity flag set while check disabled");
  AST_OVERRUN: assert property (rx_done && q.rx_full && !reg_rd &&
                                q.ctrl[serial_channel_pkg::CTL_OVR_EN] |=> q.err_ovr)
    else $error("overrun not flagged");
  AST_ERR_REQ: assert property (err_irq == (q.err_par || q.err_frm || q.err_ovr))
    else $error("error request does not follow flags");
  AST_TX_DONE: assert property (q.tx_st != serial_channel_pkg::TX_IDLE ##1
                                q.tx_st == serial_channel_pkg::TX_IDLE |-> tx_irq)
    else $error("transmit request missing at frame end");
  AST_START_REJECT: assert property (q.rx_st == serial_channel_pkg::RX_START && tick &&
                                     q.rx_tk == serial_channel_pkg::OVS_MID && rx_in
                                     |=> q.rx_st == serial_channel_pkg::RX_IDLE)
    else $error("false start bit accepted");

endmodule : async_sync_serial_channel

// >>> dv/remote_station.sv
`timescale 1ns/1ns
// Far-side station: async framer and sync shift peripheral
module remote_station (
  // Clock
  input  wire logic clk_sys,
  // Pins as seen from the far side
  input  wire logic txd,
  input  wire logic line,
  output logic      p_en,
  output logic      p_val
);
  // Async line idles high; the pin has a pull-up when nobody drives
  initial begin
    p_en  = 1'b1;
    p_val = 1'b1;
  end

  // Grab n bits at bit centres; a start never seen leaves all ones
  task automatic capture(input int n, input int bclk, output logic [11:0] v);
    int w;
    v = 12'hFFF;
    w = 0;
    while (txd !== 1'b0 && w < 4000) begin
      @(negedge clk_sys);
      w++;
    end
    repeat (bclk / 2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      v[i] = txd;
      repeat (bclk) @(negedge clk_sys);
    end
  endtask : capture

  // Send n bits in wire order, then one idle cycle so calls can follow
  task automatic send(input logic [11:0] v, input int n, input int bclk);
    for (int i = 0; i < n; i++) begin
      p_val <= v[i];
      repeat (bclk) @(posedge clk_sys);
    end
    p_val <= 1'b1;
    @(posedge clk_sys);
  endtask : send

  // Follows the block's shift clock only; data moves after each rise
  task automatic shift(input logic drive, input logic [7:0] dout, output logic [7:0] din);
    p_en  <= drive;
    p_val <= dout[0];
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      din[i] = line;
      @(posedge txd);
      @(negedge clk_sys);
      if (i < 7) p_val <= dout[i + 1];
    end
    // Released line goes back to its idle high level
    p_val <= 1'b1;
    p_en  <= 1'b1;
  endtask : shift
endmodule : remote_station

// >>> dv/async_sync_serial_channel_bench.sv
`timescale 1ns/1ns
module async_sync_serial_channel_bench;
  logic        clk_sys, rst_b, reg_wr, reg_rd, txd, rxd_o, rxd_oe;
  logic        tx_irq, rx_irq, err_irq, p_en, p_val, line;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0]  g;
  int          bad_count, checks, cycles, tx_cnt, rx_cnt, m;

  // Pin level: block drive wins, then far side, else pull-up
  assign line = rxd_oe ? rxd_o : (p_en ? p_val : 1'b1);

  async_sync_serial_channel async_sync_serial_channel_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .rxd_i(line),
    .rxd_o(rxd_o), .rxd_oe(rxd_oe), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));

  remote_station remote_station_i (
    .clk_sys(clk_sys), .txd(txd), .line(line), .p_en(p_en), .p_val(p_val));

  // 25 MHz clock
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  // Pulse counters and hang guard; pre-edge values are read, so no race
  always @(posedge clk_sys) begin
    if (tx_irq === 1'b1) tx_cnt++;
    if (rx_irq === 1'b1) rx_cnt++;
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus cycles; each leaves a gap cycle so a strobe never flips twice in a step
  task automatic wr(input logic [2:0] a, input logic [15:0] dv);
    reg_addr  <= a;
    reg_wdata <= dv;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rchk(input string what, input logic [2:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(what, exp, reg_rdata);
    @(posedge clk_sys);
  endtask : rchk

  task automatic wait_cnt(ref int c, input int mark);
    for (int i = 0; i < 2000 && c == mark; i++) @(posedge clk_sys);
  endtask : wait_cnt

  // Block transmits one frame; far side checks every bit at its centre
  task automatic tx_frame(string what, logic [15:0] ctrl, logic [15:0] baud,
                          logic [8:0] data, logic [11:0] exp, int n, int bclk);
    logic [11:0] got;
    // Reload first: a stopped divider preloads it, so the first tick is not late
    wr(serial_channel_pkg::REG_BAUD, baud);
    wr(serial_channel_pkg::REG_CTRL, ctrl);
    m = tx_cnt;
    fork
      remote_station_i.capture(n, bclk, got);
      wr(serial_channel_pkg::REG_TXDATA, {7'h00, data});
    join
    wait_cnt(tx_cnt, m);
    chk(what, {4'h0, exp}, {4'h0, got});
    chk("tx pulses", 16'h0001, 16'(tx_cnt - m));
    $display("test %s done", what);
  endtask : tx_frame

  // Far side sends one frame; status then data are read back
  task automatic rx_frame(string what, logic [15:0] ctrl, logic [11:0] fr, int n,
                          logic [15:0] sts, logic [15:0] data);
    wr(serial_channel_pkg::REG_CTRL, ctrl);
    m = rx_cnt;
    remote_station_i.send(fr, n, 32);
    wait_cnt(rx_cnt, m);
    chk("rx pulses", 16'h0001, 16'(rx_cnt - m));
    rchk("status", serial_channel_pkg::REG_STATUS, sts);
    rchk("rx data", serial_channel_pkg::REG_RXDATA, data);
    chk("err level", {15'h0, sts[4:2] != 3'h0}, {15'h0, err_irq});
    $display("test %s done", what);
  endtask : rx_frame

  initial begin
    reg_addr  = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    rst_b     = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Reset values, field widths, unmapped place, refused send while stopped
    rchk("ctrl", serial_channel_pkg::REG_CTRL, 16'h0001);
    rchk("status", serial_channel_pkg::REG_STATUS, 16'h0000);
    wr(3'h7, 16'hFFFF);
    rchk("unmapped", 3'h7, 16'h0000);
    wr(serial_channel_pkg::REG_BAUD, 16'hFFFF);
    rchk("baud", serial_channel_pkg::REG_BAUD, 16'h1FFF);
    m = tx_cnt;
    wr(serial_channel_pkg::REG_TXDATA, 16'h0055);
    repeat (40) @(posedge clk_sys);
    chk("stopped txd", 16'h0001, {15'h0, txd});
    chk("stopped pulses", 16'h0000, 16'(tx_cnt - m));
    $display("test registers done");
    // Transmit formats and rates
    tx_frame("tx8", 16'h0301, 16'h0000, 9'h035, {3'b111, 8'h35, 1'b0}, 10, 32);
    tx_frame("tx8 slow pre", 16'h0381, 16'h0000, 9'h0C9, {3'b111, 8'hC9, 1'b0}, 10, 48);
    tx_frame("tx8 reload1", 16'h0301, 16'h0001, 9'h01E, {3'b111, 8'h1E, 1'b0}, 10, 64);
    tx_frame("tx9 two stops", 16'h0306, 16'h0000, 9'h1A5, {2'b11, 9'h1A5, 1'b0}, 12, 32);
    tx_frame("tx parity", 16'h0309, 16'h0000, 9'h007, {3'b111, 8'h07, 1'b0}, 11, 32);
    // Receive, errors on and off
    rx_frame("rx8", 16'h0301, {3'b111, 8'h5A, 1'b0}, 10, 16'h0002, 16'h005A);
    rchk("full cleared", serial_channel_pkg::REG_STATUS, 16'h0000);
    rx_frame("framing", 16'h0311, {3'b110, 8'hA5, 1'b0}, 10, 16'h000A, 16'h00A5);
    wr(serial_channel_pkg::REG_STATUS, 16'h0008);
    rchk("framing clear", serial_channel_pkg::REG_STATUS, 16'h0000);
    chk("err cleared", 16'h0000, {15'h0, err_irq});
    rx_frame("framing off", 16'h0301, {3'b110, 8'hA5, 1'b0}, 10, 16'h0002, 16'h00A5);
    rx_frame("parity", 16'h0309, {3'b110, 8'h07, 1'b0}, 11, 16'h0006, 16'h0007);
    wr(serial_channel_pkg::REG_STATUS, 16'h0004);
    rx_frame("wake", 16'h0303, {3'b111, 8'h42, 1'b0}, 11, 16'h0002, 16'h0142);
    // Low pulse of a quarter bit must not start a character
    m = rx_cnt;
    remote_station_i.send(12'h000, 1, 8);
    repeat (40) @(posedge clk_sys);
    chk("glitch pulses", 16'h0000, 16'(rx_cnt - m));
    rchk("glitch status", serial_channel_pkg::REG_STATUS, 16'h0000);
    // Overrun: second character lands while the first is unread
    wr(serial_channel_pkg::REG_CTRL, 16'h0321);
    m = rx_cnt;
    remote_station_i.send({3'b111, 8'h11, 1'b0}, 10, 32);
    remote_station_i.send({3'b111, 8'h22, 1'b0}, 10, 32);
    wait_cnt(rx_cnt, m + 1);
    chk("overrun err", 16'h0001, {15'h0, err_irq});
    rchk("overrun", serial_channel_pkg::REG_STATUS, 16'h0012);
    rchk("overrun data", serial_channel_pkg::REG_RXDATA, 16'h0022);
    wr(serial_channel_pkg::REG_STATUS, 16'h0010);
    $display("test overrun done");
    // Loopback: own output reaches own receiver
    wr(serial_channel_pkg::REG_CTRL, 16'h0341);
    // Wait for the stop bit to end, or the sync send below would be dropped
    m = tx_cnt;
    wr(serial_channel_pkg::REG_TXDATA, 16'h00C3);
    wait_cnt(tx_cnt, m);
    rchk("loop data", serial_channel_pkg::REG_RXDATA, 16'h00C3);
    $display("test loopback done");
    // Sync send: data pin driven by the block, far side follows the clock
    wr(serial_channel_pkg::REG_CTRL, 16'h0200);
    fork
      remote_station_i.shift(1'b0, 8'h00, g);
      wr(serial_channel_pkg::REG_TXDATA, 16'h0096);
    join
    chk("sync out", 16'h0096, {8'h00, g});
    // Sync receive: far side shifts data in on the block's clock
    wr(serial_channel_pkg::REG_CTRL, 16'h0300);
    m = rx_cnt;
    fork
      remote_station_i.shift(1'b1, 8'h3C, g);
      wr(serial_channel_pkg::REG_TXDATA, 16'h0000);
    join
    wait_cnt(rx_cnt, m);
    rchk("sync in", serial_channel_pkg::REG_RXDATA, 16'h003C);
    $display("test sync done");
    conclude();
  end
endmodule : async_sync_serial_channel_bench
